// file: tdmhc_map.svh
// Register map, field positions and reset values of the highway common control.
// Assumes an 8-bit register port with a 4-bit word address.
`ifndef TDMHC_MAP_SVH
`define TDMHC_MAP_SVH

`define TDMHC_ADDR_W          4
`define TDMHC_ADDR_CTRL_A     4'h0
`define TDMHC_ADDR_OFFS       4'h1
`define TDMHC_ADDR_IDLE       4'h2
`define TDMHC_ADDR_STAT       4'h3

`define TDMHC_CTRL_A_RST      8'h00
`define TDMHC_CTRL_A_MASK     8'h9E
`define TDMHC_OFFS_RST        8'h00
`define TDMHC_IDLE_RST        8'h7F

`define TDMHC_B_RATIO         1
`define TDMHC_B_RATE_LO       2
`define TDMHC_B_RATE_HI       3
`define TDMHC_B_MASTER        4
`define TDMHC_B_ENABLE        7

`define TDMHC_B_TX_DLY_LSB    0
`define TDMHC_B_TX_DLY_MSB    2
`define TDMHC_B_TX_EDGE       3
`define TDMHC_B_RX_DLY_LSB    4
`define TDMHC_B_RX_DLY_MSB    6
`define TDMHC_B_RX_EDGE       7

`define TDMHC_LAST_2M         10'h0FF
`define TDMHC_LAST_4M         10'h1FF
`define TDMHC_LAST_8M         10'h3FF

`endif

// file: tdmhc_pkg.sv
// Types and shared decoding of the highway common control.
// Assumes tdmhc_map.svh is on the include path.
`include "tdmhc_map.svh"

package tdmhc_pkg;

  typedef enum logic [1:0] {
    TDMHC_RATE_2M   = 2'b00,
    TDMHC_RATE_4M   = 2'b01,
    TDMHC_RATE_8M   = 2'b10,
    TDMHC_RATE_RSVD = 2'b11
  } tdmhc_rate_t;

  typedef enum logic [1:0] {
    TDMHC_GEN_IDLE  = 2'b00,
    TDMHC_GEN_PEND  = 2'b01,
    TDMHC_GEN_DRIVE = 2'b10
  } tdmhc_gen_t;

  // Last bit position of a frame; the reserved code falls back to the lowest rate.
  function automatic logic [9:0] tdmhc_frame_last(input tdmhc_rate_t rate);
    case (rate)
      TDMHC_RATE_4M: tdmhc_frame_last = `TDMHC_LAST_4M;
      TDMHC_RATE_8M: tdmhc_frame_last = `TDMHC_LAST_8M;
      default:       tdmhc_frame_last = `TDMHC_LAST_2M;
    endcase
  endfunction

endpackage

// file: tdmhc_sync2.sv
// Two-stage synchroniser with edge pulses for one pin.
// Assumes the pin is asynchronous to ref_clk_i and far slower than it.
`timescale 1ns/1ns

module tdmhc_sync2 (
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);

  logic meta_ff;
  logic sync_ff;
  logic prev_ff;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      meta_ff <= pin_i;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign level_o = sync_ff;
  assign rise_o  = sync_ff & ~prev_ff;
  assign fall_o  = ~sync_ff & prev_ff;

endmodule // tdmhc_sync2

// file: tdmhc_slot_timer.sv
// Bit position counter of one highway direction.
// Assumes edge pulses of the synchronised highway clock; bits start on its rising edge.
`timescale 1ns/1ns

module tdmhc_slot_timer (
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  clk_rise_i,
  input  wire logic                  clk_fall_i,
  input  wire logic                  sync_i,
  input  wire logic                  edge_sel_i,
  input  wire logic [2:0]            bit_delay_i,
  input  tdmhc_pkg::tdmhc_rate_t     rate_i,
  output logic                       framed_o,
  output logic                       bit_stb_o,
  output logic [9:0]                 pos_o
);
  import tdmhc_pkg::*;

  logic       sync_hit;
  logic [2:0] dly_ff;
  logic       first_ff;
  logic       framed_ff;
  logic       stb_ff;
  logic [9:0] pos_ff;

  assign sync_hit = sync_i & (edge_sel_i ? clk_rise_i : clk_fall_i);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dly_ff    <= 3'h0;
      first_ff  <= 1'b0;
      framed_ff <= 1'b0;
      stb_ff    <= 1'b0;
      pos_ff    <= 10'h000;
    end else if (sync_hit) begin
      dly_ff    <= bit_delay_i;
      first_ff  <= 1'b1;
      framed_ff <= 1'b1;
      stb_ff    <= 1'b0;
    end else if (clk_rise_i && framed_ff) begin
      if (dly_ff != 3'h0) begin
        dly_ff <= dly_ff - 3'h1;
        stb_ff <= 1'b0;
      end else begin
        stb_ff   <= 1'b1;
        first_ff <= 1'b0;
        if (first_ff || pos_ff >= tdmhc_frame_last(rate_i)) begin
          pos_ff <= 10'h000;
        end else begin
          pos_ff <= pos_ff + 10'h001;
        end
      end
    end else begin
      stb_ff <= 1'b0;
    end
  end

  assign framed_o  = framed_ff;
  assign bit_stb_o = stb_ff;
  assign pos_o     = pos_ff;

  property p_hit_edge;
    @(posedge ref_clk_i) disable iff (rst_i)
      sync_hit |-> (edge_sel_i ? clk_rise_i : clk_fall_i) && !(edge_sel_i ? clk_fall_i : clk_rise_i);
  endproperty
  a_hit_edge: assert property (p_hit_edge) else $error("Sync taken on wrong edge.");

  property p_first_bit;
    @(posedge ref_clk_i) disable iff (rst_i)
      stb_ff && $past(first_ff) && $past(clk_rise_i) |-> pos_ff == 10'h000 && $past(dly_ff) == 3'h0;
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("First bit not at delay end.");

  c_delayed: cover property (@(posedge ref_clk_i) sync_hit && bit_delay_i != 3'h0);

endmodule // tdmhc_slot_timer

// file: tdmhc_highway_ctrl.sv
// Common timing and enable control of one framer's TDM system highway.
// Assumes line-side logic on ref_clk_i and highway pins from another clock domain.
//
// Overview of operation
// - Slave mode times transmit from external sync.
// - Master mode drives sync derived from line.
// - Receive timing ignores the master mode bit.
// - Highway transmission only while enable is set.
// - Disabled: idle code to line, output tristated.
// - Transmit bit delay after sync, in clocks.
// - Transmit sync edge: 0 falling, 1 rising.
// - Receive bit delay after sync, in clocks.
// - Receive sync edge: 0 falling, 1 rising.
// - Offset and edge register resets to zero.
// - Clock ratio zero: clock equals data rate.
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`include "tdmhc_map.svh"

module tdmhc_highway_ctrl (
  input  wire logic                      ref_clk_i,
  input  wire logic                      rst_i,
  input  wire logic [`TDMHC_ADDR_W-1:0]  reg_addr_i,
  input  wire logic [7:0]                reg_wdata_i,
  input  wire logic                      reg_wr_i,
  input  wire logic                      reg_rd_i,
  output logic [7:0]                     reg_rdata_o,
  input  wire logic                      highway_clock_i,
  input  wire logic                      highway_frame_sync_i,
  output logic                           highway_frame_sync_o,
  output logic                           highway_frame_sync_oe_o,
  output logic                           tx_highway_data_o,
  output logic                           tx_highway_data_oe_o,
  input  wire logic                      rx_highway_data_i,
  input  wire logic                      line_frame_i,
  input  wire logic [7:0]                tx_line_byte_i,
  output logic                           tx_byte_take_o,
  output logic [6:0]                     tx_slot_o,
  output logic [7:0]                     line_byte_o,
  output logic                           line_byte_valid_o,
  output logic [6:0]                     line_slot_o
);
  import tdmhc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.

  logic [7:0]  ctrl_a_ff;
  logic [7:0]  offs_ff;
  logic [7:0]  idle_ff;
  logic [7:0]  rdata_ff;
  logic [7:0]  nxt_rdata;
  logic [7:0]  status;
  tdmhc_rate_t rate;
  logic        master;
  logic        enable;

  // Only the fields of this block are stored; other bits read back as zero.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_a_ff <= `TDMHC_CTRL_A_RST;
    end else if (reg_wr_i && reg_addr_i == `TDMHC_ADDR_CTRL_A) begin
      ctrl_a_ff <= reg_wdata_i & `TDMHC_CTRL_A_MASK;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      offs_ff <= `TDMHC_OFFS_RST;
    end else if (reg_wr_i && reg_addr_i == `TDMHC_ADDR_OFFS) begin
      offs_ff <= reg_wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      idle_ff <= `TDMHC_IDLE_RST;
    end else if (reg_wr_i && reg_addr_i == `TDMHC_ADDR_IDLE) begin
      idle_ff <= reg_wdata_i;
    end
  end

  // The clock ratio bit is stored for software; only ratio zero is defined.
  assign rate   = tdmhc_rate_t'(ctrl_a_ff[`TDMHC_B_RATE_HI:`TDMHC_B_RATE_LO]);
  assign master = ctrl_a_ff[`TDMHC_B_MASTER];
  assign enable = ctrl_a_ff[`TDMHC_B_ENABLE];

  always_comb begin
    case (reg_addr_i)
      `TDMHC_ADDR_CTRL_A: nxt_rdata = ctrl_a_ff;
      `TDMHC_ADDR_OFFS:   nxt_rdata = offs_ff;
      `TDMHC_ADDR_IDLE:   nxt_rdata = idle_ff;
      `TDMHC_ADDR_STAT:   nxt_rdata = status;
      default:            nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= reg_rd_i ? nxt_rdata : 8'h00;
    end
  end

  assign reg_rdata_o = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Highway pin synchronisers.

  logic hclk_lvl;
  logic hclk_rise;
  logic hclk_fall;
  logic fs_lvl;
  logic rxd_lvl;

  tdmhc_sync2 u_sync_clk (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .pin_i     (highway_clock_i),
    .level_o   (hclk_lvl),
    .rise_o    (hclk_rise),
    .fall_o    (hclk_fall)
  );

  tdmhc_sync2 u_sync_fs (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .pin_i     (highway_frame_sync_i),
    .level_o   (fs_lvl),
    .rise_o    (),
    .fall_o    ()
  );

  tdmhc_sync2 u_sync_rxd (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .pin_i     (rx_highway_data_i),
    .level_o   (rxd_lvl),
    .rise_o    (),
    .fall_o    ()
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Frame sync generation in master mode.

  tdmhc_gen_t gen_state_ff;
  logic       gen_fs_ff;

  // A line frame pulse arms the generator; the pulse spans one falling-to-falling period.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gen_state_ff <= TDMHC_GEN_IDLE;
      gen_fs_ff    <= 1'b0;
    end else if (!master) begin
      gen_state_ff <= TDMHC_GEN_IDLE;
      gen_fs_ff    <= 1'b0;
    end else begin
      case (gen_state_ff)
        TDMHC_GEN_IDLE: begin
          if (line_frame_i) begin
            gen_state_ff <= TDMHC_GEN_PEND;
          end
        end
        TDMHC_GEN_PEND: begin
          if (hclk_fall) begin
            gen_state_ff <= TDMHC_GEN_DRIVE;
            gen_fs_ff    <= 1'b1;
          end
        end
        TDMHC_GEN_DRIVE: begin
          if (hclk_fall) begin
            gen_state_ff <= TDMHC_GEN_IDLE;
            gen_fs_ff    <= 1'b0;
          end
        end
        default: begin
          gen_state_ff <= TDMHC_GEN_IDLE;
          gen_fs_ff    <= 1'b0;
        end
      endcase
    end
  end

  assign highway_frame_sync_o    = gen_fs_ff;
  assign highway_frame_sync_oe_o = master;

  ////////////////////////////////////////////////////////////////////////////////
  // Slot timing of both directions.

  logic       tx_sync_src;
  logic       tx_framed;
  logic       tx_stb;
  logic [9:0] tx_pos;
  logic       rx_framed;
  logic       rx_stb;
  logic [9:0] rx_pos;

  assign tx_sync_src = master ? gen_fs_ff : fs_lvl;

  tdmhc_slot_timer u_tx_timer (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .clk_rise_i  (hclk_rise),
    .clk_fall_i  (hclk_fall),
    .sync_i      (tx_sync_src),
    .edge_sel_i  (offs_ff[`TDMHC_B_TX_EDGE]),
    .bit_delay_i (offs_ff[`TDMHC_B_TX_DLY_MSB:`TDMHC_B_TX_DLY_LSB]),
    .rate_i      (rate),
    .framed_o    (tx_framed),
    .bit_stb_o   (tx_stb),
    .pos_o       (tx_pos)
  );

  // The receive path always follows the sync pin, whatever the master bit.
  tdmhc_slot_timer u_rx_timer (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .clk_rise_i  (hclk_rise),
    .clk_fall_i  (hclk_fall),
    .sync_i      (fs_lvl),
    .edge_sel_i  (offs_ff[`TDMHC_B_RX_EDGE]),
    .bit_delay_i (offs_ff[`TDMHC_B_RX_DLY_MSB:`TDMHC_B_RX_DLY_LSB]),
    .rate_i      (rate),
    .framed_o    (rx_framed),
    .bit_stb_o   (rx_stb),
    .pos_o       (rx_pos)
  );

  assign status = {4'h0, gen_fs_ff, (rate == TDMHC_RATE_RSVD), rx_framed, tx_framed};

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit highway data.

  logic [7:0] tx_shift_ff;
  logic       tx_data_ff;
  logic       tx_oe_ff;

  assign tx_byte_take_o = tx_stb && tx_pos[2:0] == 3'h0;
  assign tx_slot_o      = tx_pos[9:3];

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_shift_ff <= 8'h00;
      tx_data_ff  <= 1'b0;
    end else if (tx_byte_take_o) begin
      tx_shift_ff <= {tx_line_byte_i[6:0], 1'b0};
      tx_data_ff  <= tx_line_byte_i[7];
    end else if (tx_stb) begin
      tx_shift_ff <= {tx_shift_ff[6:0], 1'b0};
      tx_data_ff  <= tx_shift_ff[7];
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_oe_ff <= 1'b0;
    end else begin
      tx_oe_ff <= enable && tx_framed;
    end
  end

  assign tx_highway_data_o    = tx_data_ff;
  assign tx_highway_data_oe_o = tx_oe_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Receive highway data towards the line.

  logic [7:0] rx_shift_ff;
  logic [7:0] line_byte_ff;
  logic       line_valid_ff;
  logic [6:0] line_slot_ff;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_shift_ff   <= 8'h00;
      line_byte_ff  <= 8'h00;
      line_valid_ff <= 1'b0;
      line_slot_ff  <= 7'h00;
    end else begin
      line_valid_ff <= 1'b0;
      if (rx_stb) begin
        rx_shift_ff <= {rx_shift_ff[6:0], rxd_lvl};
        if (rx_pos[2:0] == 3'h7) begin
          line_byte_ff  <= enable ? {rx_shift_ff[6:0], rxd_lvl} : idle_ff;
          line_valid_ff <= 1'b1;
          line_slot_ff  <= rx_pos[9:3];
        end
      end
    end
  end

  assign line_byte_o       = line_byte_ff;
  assign line_byte_valid_o = line_valid_ff;
  assign line_slot_o       = line_slot_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_tx_quiet;
    @(posedge ref_clk_i) disable iff (rst_i)
      !enable ##1 !enable |-> !tx_highway_data_oe_o;
  endproperty
  a_tx_quiet: assert property (p_tx_quiet) else $error("Highway driven while disabled.");

  property p_tx_on;
    @(posedge ref_clk_i) disable iff (rst_i)
      tx_highway_data_oe_o |-> $past(enable) && $past(tx_framed);
  endproperty
  a_tx_on: assert property (p_tx_on) else $error("Highway driven without enable.");

  property p_idle_code;
    @(posedge ref_clk_i) disable iff (rst_i)
      line_byte_valid_o && !$past(enable) |-> line_byte_o == $past(idle_ff);
  endproperty
  a_idle_code: assert property (p_idle_code) else $error("Idle code not sent to line.");

  property p_master_gen;
    @(posedge ref_clk_i) disable iff (rst_i)
      master && gen_state_ff == TDMHC_GEN_IDLE && line_frame_i
        |-> ##[1:200] (highway_frame_sync_o || !master);
  endproperty
  a_master_gen: assert property (p_master_gen) else $error("Frame sync not generated.");

  property p_slave_quiet;
    @(posedge ref_clk_i) disable iff (rst_i)
      !master |-> !highway_frame_sync_oe_o ##1 (master || !highway_frame_sync_o);
  endproperty
  a_slave_quiet: assert property (p_slave_quiet) else $error("Sync driven in slave mode.");

  property p_rx_free;
    @(posedge ref_clk_i) disable iff (rst_i)
      $changed(master) && !$changed(fs_lvl) |=> rx_framed == $past(rx_framed) || fs_lvl;
  endproperty
  a_rx_free: assert property (p_rx_free) else $error("Receive timing moved by master bit.");

  property p_reset_offs;
    @(posedge ref_clk_i) $fell(rst_i) |-> offs_ff == 8'h00;
  endproperty
  a_reset_offs: assert property (p_reset_offs) else $error("Offset register not cleared.");

  property p_rate_len;
    @(posedge ref_clk_i) disable iff (rst_i)
      tx_stb |-> tx_pos <= tdmhc_frame_last(rate) || $changed(rate);
  endproperty
  a_rate_len: assert property (p_rate_len) else $error("Bit position beyond frame.");

  property p_rx_edge;
    @(posedge ref_clk_i) disable iff (rst_i)
      rx_stb |-> $past(hclk_rise);
  endproperty
  a_rx_edge: assert property (p_rx_edge) else $error("Receive bit off clock edge.");

  c_master: cover property (@(posedge ref_clk_i) master && highway_frame_sync_o);
  c_idle:   cover property (@(posedge ref_clk_i) line_byte_valid_o && !enable);
  c_tx_run: cover property (@(posedge ref_clk_i) tx_highway_data_oe_o && tx_byte_take_o);
  c_8m:     cover property (@(posedge ref_clk_i) tx_stb && tx_pos == 10'h3FF);

endmodule // tdmhc_highway_ctrl

// file: tdmhc_backplane_model.sv
// Behavioural backplane: highway clock, frame sync, receive data and transmit capture.
// Assumes the bench resolves the shared frame-sync line from both drivers.
`timescale 1ns/1ns

module tdmhc_backplane_model (
  input  wire logic        run_i,
  input  wire logic        drive_sync_i,
  input  wire logic        sync_on_fall_i,
  input  wire logic [10:0] frame_bits_i,
  input  wire logic [2:0]  rx_dly_i,
  input  wire logic [2:0]  tx_dly_i,
  input  wire logic        tx_data_i,
  input  wire logic        tx_oe_i,
  output logic             highway_clock_o,
  output logic             sync_o,
  output logic             sync_oe_o,
  output logic             rx_data_o,
  output logic [7:0]       tx_byte_o,
  output logic             frame_start_o
);
  logic [10:0] cnt_ff     = 11'h000;
  logic        sync_r_ff  = 1'b0;
  logic        sync_f_ff  = 1'b0;
  logic [7:0]  sh_ff      = 8'h00;
  logic        last_tx_ff = 1'b0;
  logic        tx_wire;

  // A released transmit line shows a changing level, never the last driven bit.
  assign tx_wire       = tx_oe_i ? tx_data_i : ~last_tx_ff;
  // Sync changes on the edge opposite to the one that samples it.
  assign sync_o        = sync_on_fall_i ? sync_f_ff : sync_r_ff;
  assign sync_oe_o     = drive_sync_i;
  assign frame_start_o = (cnt_ff == 11'h000);

  ////////////////////////////////////////////////////////////////////////////
  always begin
    #63;
    highway_clock_o = run_i;
    #62;
    highway_clock_o = 1'b0;
  end

  always @(posedge highway_clock_o) begin
    cnt_ff    <= (cnt_ff >= frame_bits_i - 11'h001) ? 11'h000 : cnt_ff + 11'h001;
    sync_r_ff <= (cnt_ff == frame_bits_i - 11'h002);
  end

  // Receive bits follow the receive offset; slot s carries 30h plus s, MSB first.
  always @(negedge highway_clock_o) begin : fall_side
    int         rx_pos;
    int         tx_pos;
    logic [7:0] rb;
    rx_pos = (int'(cnt_ff) + 1 + 2 * int'(frame_bits_i) - int'(rx_dly_i)) % int'(frame_bits_i);
    tx_pos = (int'(cnt_ff) + 2 * int'(frame_bits_i) - int'(tx_dly_i)) % int'(frame_bits_i);
    rb = 8'h30 + 8'(rx_pos / 8);
    sync_f_ff  <= (cnt_ff == frame_bits_i - 11'h002);
    rx_data_o  <= rb[7 - (rx_pos % 8)];
    last_tx_ff <= tx_wire;
    sh_ff      <= {sh_ff[6:0], tx_wire};
    if (tx_pos % 8 == 7)
      tx_byte_o <= {sh_ff[6:0], tx_wire};
  end
endmodule // tdmhc_backplane_model

// file: tb_top.sv
// Self-checking bench of the highway common control.
// Assumes the design files and the backplane model are compiled before it.
`timescale 1ns/1ns
`include "tdmhc_map.svh"

module tb_top;
  logic                     ref_clk_i      = 1'b0;
  logic                     rst_i          = 1'b1;
  logic [`TDMHC_ADDR_W-1:0] reg_addr_i     = 4'h0;
  logic [7:0]               reg_wdata_i    = 8'h00;
  logic                     reg_wr_i       = 1'b0;
  logic                     reg_rd_i       = 1'b0;
  logic                     line_frame_i   = 1'b0;
  logic [7:0]               tx_line_byte_i = 8'hA6;
  logic                     drive_sync     = 1'b1;
  logic                     sync_on_fall   = 1'b0;
  logic [10:0]              frame_bits     = 11'h100;
  logic [2:0]               rx_dly         = 3'h0;
  logic [2:0]               tx_dly         = 3'h0;
  logic [7:0]               reg_rdata_o;
  logic                     hw_clk;
  logic                     fs_pin;
  logic                     highway_frame_sync_o;
  logic                     highway_frame_sync_oe_o;
  logic                     tx_highway_data_o;
  logic                     tx_highway_data_oe_o;
  logic                     rx_data;
  logic [7:0]               line_byte_o;
  logic                     line_byte_valid_o;
  logic [6:0]               line_slot_o;
  logic [6:0]               tx_slot;
  logic                     m_sync;
  logic                     m_sync_oe;
  logic                     m_frame;
  logic [7:0]               seen_tx_byte;
  int                       error_cnt      = 0;
  int                       n_compared     = 0;
  int                       cycle_cnt      = 0;

  // The frame-sync line has a pull-down when nobody drives it.
  assign fs_pin = highway_frame_sync_oe_o ? highway_frame_sync_o : (m_sync_oe ? m_sync : 1'b0);

  always #2 ref_clk_i = ~ref_clk_i;

  tdmhc_highway_ctrl dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .highway_clock_i(hw_clk), .highway_frame_sync_i(fs_pin),
    .highway_frame_sync_o(highway_frame_sync_o),
    .highway_frame_sync_oe_o(highway_frame_sync_oe_o),
    .tx_highway_data_o(tx_highway_data_o), .tx_highway_data_oe_o(tx_highway_data_oe_o),
    .rx_highway_data_i(rx_data), .line_frame_i(line_frame_i),
    .tx_line_byte_i(tx_line_byte_i), .tx_byte_take_o(), .tx_slot_o(tx_slot),
    .line_byte_o(line_byte_o), .line_byte_valid_o(line_byte_valid_o),
    .line_slot_o(line_slot_o)
  );

  tdmhc_backplane_model partner (
    .run_i(1'b1), .drive_sync_i(drive_sync), .sync_on_fall_i(sync_on_fall),
    .frame_bits_i(frame_bits), .rx_dly_i(rx_dly), .tx_dly_i(tx_dly),
    .tx_data_i(tx_highway_data_o), .tx_oe_i(tx_highway_data_oe_o),
    .highway_clock_o(hw_clk), .sync_o(m_sync), .sync_oe_o(m_sync_oe),
    .rx_data_o(rx_data), .tx_byte_o(seen_tx_byte), .frame_start_o(m_frame)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (error_cnt == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i    <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i   <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask

  // Follows the line bytes of one frame from slot 0 on.
  task automatic check_line(input int n, input logic en, input logic [7:0] idle);
    logic [6:0] slot;
    logic       started;
    int         t;
    slot    = 7'h00;
    started = 1'b0;
    @(posedge m_frame);
    repeat (n + 3) begin
      t = 0;
      do begin
        @(posedge ref_clk_i);
        #1;
        t++;
      end while (line_byte_valid_o !== 1'b1 && t < 400);
      if (line_slot_o === 7'h00)
        started = 1'b1;
      if (started) begin
        check({1'b0, line_slot_o}, {1'b0, slot});
        check({1'b0, tx_slot}, {1'b0, slot});
        check(line_byte_o, en ? 8'h30 + {1'b0, slot} : idle);
        check({7'h00, tx_highway_data_oe_o}, {7'h00, en});
        slot++;
      end
    end
    check({7'h00, started}, 8'h01);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic scen_regs();
    logic [7:0] d;
    check({7'h00, highway_frame_sync_oe_o}, 8'h00);
    reg_rd(`TDMHC_ADDR_CTRL_A, d);
    check(d, `TDMHC_CTRL_A_RST);
    reg_rd(`TDMHC_ADDR_OFFS, d);
    check(d, 8'h00);
    reg_rd(`TDMHC_ADDR_IDLE, d);
    check(d, `TDMHC_IDLE_RST);
    reg_wr(`TDMHC_ADDR_CTRL_A, 8'h9F);
    reg_wr(4'hF, 8'hFF);
    reg_rd(`TDMHC_ADDR_CTRL_A, d);
    check(d, `TDMHC_CTRL_A_MASK);
    reg_rd(4'hF, d);
    check(d, 8'h00);
    reg_wr(`TDMHC_ADDR_CTRL_A, 8'h0C);
    reg_rd(`TDMHC_ADDR_STAT, d);
    check(d, 8'h04);
    reg_wr(`TDMHC_ADDR_CTRL_A, 8'h00);
  endtask

  task automatic scen_enabled();
    logic [7:0] d;
    reg_wr(`TDMHC_ADDR_IDLE, 8'h5A);
    check_line(6, 1'b0, 8'h5A);
    reg_wr(`TDMHC_ADDR_CTRL_A, 8'h80);
    check_line(10, 1'b1, 8'h5A);
    check(seen_tx_byte, 8'hA6);
    reg_rd(`TDMHC_ADDR_STAT, d);
    check(d, 8'h03);
  endtask

  task automatic scen_offsets();
    logic [7:0] d;
    rx_dly       = 3'h3;
    tx_dly       = 3'h5;
    sync_on_fall = 1'b1;
    reg_wr(`TDMHC_ADDR_OFFS, 8'hBD);
    check_line(10, 1'b1, 8'h5A);
    check(seen_tx_byte, 8'hA6);
    reg_rd(`TDMHC_ADDR_OFFS, d);
    check(d, 8'hBD);
    frame_bits = 11'h200;
    reg_wr(`TDMHC_ADDR_CTRL_A, 8'h84);
    check_line(42, 1'b1, 8'h5A);
  endtask

  task automatic scen_master();
    int t;
    drive_sync = 1'b0;
    reg_wr(`TDMHC_ADDR_CTRL_A, 8'h94);
    #1;
    check({7'h00, highway_frame_sync_oe_o}, 8'h01);
    @(posedge ref_clk_i);
    line_frame_i <= 1'b1;
    @(posedge ref_clk_i);
    line_frame_i <= 1'b0;
    t = 0;
    while (highway_frame_sync_o !== 1'b1 && t < 200) begin
      @(posedge ref_clk_i);
      #1;
      t++;
    end
    t = 0;
    while (highway_frame_sync_o === 1'b1 && t < 100) begin
      @(posedge ref_clk_i);
      #1;
      t++;
    end
    check({7'h00, t >= 30 && t <= 33}, 8'h01);
    reg_wr(`TDMHC_ADDR_CTRL_A, 8'h84);
    #1;
    check({7'h00, highway_frame_sync_oe_o}, 8'h00);
    drive_sync = 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk_i) begin
    cycle_cnt++;
    if (cycle_cnt == 90000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    scen_regs();
    scen_enabled();
    scen_offsets();
    scen_master();
    tally_and_finish();
  end
endmodule // tb_top
